// file: rtl/transfer_multiply_defs.svh
// Constants for the transfer and multiply execution block
`ifndef TRANSFER_MULTIPLY_DEFS_SVH
`define TRANSFER_MULTIPLY_DEFS_SVH
`define IMM4_MIN        (-8)
`define IMM4_MAX        7
`define NIB_HI_MSB      7
`define NIB_HI_LSB      4
`define NIB_LO_MSB      3
`define NIB_LO_LSB      0
`define BYTE_W          8
`define WORD_W          16
`define REG_CNT         8
`define RESET_WORD      16'h0000
`define RESET_ADDR      20'h00000
`endif

// file: rtl/transfer_multiply_pkg.sv
// Types for the transfer and multiply execution block
package transfer_multiply_pkg;
  typedef enum logic [2:0] {
    OP_PLAIN,
    OP_EFF_ADDR,
    OP_NIBBLE,
    OP_SMUL,
    OP_UMUL
  } op_t;
  typedef enum logic [1:0] {
    FMT_GENERAL,
    FMT_QUICK,
    FMT_SHORT,
    FMT_ZERO
  } fmt_t;
  typedef enum logic [1:0] {
    DIR_HH,
    DIR_HL,
    DIR_LH,
    DIR_LL
  } dir_t;
  // Operand selectors: registers, immediate, or memory
  typedef enum logic [3:0] {
    SEL_ACC_LOW,
    SEL_ACC_HIGH,
    SEL_R1L,
    SEL_R1H,
    SEL_DATA0,
    SEL_DATA1,
    SEL_DATA2,
    SEL_DATA3,
    SEL_ADDR0,
    SEL_ADDR1,
    SEL_IMM,
    SEL_MEM
  } sel_t;
endpackage

// file: rtl/reg_bank.sv
// Small register bank with registered read data
`timescale 1ns/100ps
`include "transfer_multiply_defs.svh"
module reg_bank (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  input  wire logic [2:0]  wrIdx,
  input  wire logic [15:0] wrData,
  input  wire logic        wrEn,
  input  wire logic [2:0]  rdIdx,
  output logic      [15:0] rdData
);
  logic [15:0] bank_ff [`REG_CNT];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `REG_CNT; i++) begin
        bank_ff[i] <= `RESET_WORD;
      end
      rdData <= `RESET_WORD;
    end else if (clkEn) begin
      if (wrEn) begin
        bank_ff[wrIdx] <= wrData;
      end
      rdData <= bank_ff[rdIdx];
    end
  end
endmodule // reg_bank

// file: rtl/transfer_multiply_exec.sv
// Execution of transfer, effective-address, nibble and multiply operations
// Functional notes
// RL1: quick immediate limited to -8..+7
// RL2: short format is byte only, except immediate-to-address
// RL3: short format: source and destination differ
// RL4: low accumulator byte goes only to second address
// RL5: high accumulator byte goes only to first address
// RL6: short immediate to address allows byte, word
// RL7: effective-address transfer stores address, flags kept
// RL8: nibble copy by four direction codes
// RL9: nibble transfer uses low accumulator byte
// RL10: signed multiply, two's complement, flags kept
// RL11: unsigned multiply, magnitudes, flags kept
// RL12: byte multiply: 8-bit operands, 16-bit product
// RL13: word multiply: 16-bit operands, 32-bit product
// RL14: byte multiply uses address register low byte
// RL15: word product to matching register pair
// RL16: byte multiply never uses two address registers
// RL17: nibble transfer keeps other destination nibble
`timescale 1ns/100ps
`include "transfer_multiply_defs.svh"
module transfer_multiply_exec
  import transfer_multiply_pkg::*;
(
  input  wire logic                              core_clk,
  input  wire logic                              nrst,
  input  wire logic                              clkEn,
  input  wire logic                              opValid,
  input  wire transfer_multiply_pkg::op_t        opCode,
  input  wire transfer_multiply_pkg::fmt_t       opFmt,
  input  wire transfer_multiply_pkg::dir_t       nibDir,
  input  wire logic                              opWord,
  input  wire transfer_multiply_pkg::sel_t       srcSel,
  input  wire transfer_multiply_pkg::sel_t       dstSel,
  input  wire logic [15:0]                       srcVal,
  input  wire logic [15:0]                       dstVal,
  input  wire logic [15:0]                       immVal,
  input  wire logic [19:0]                       srcAddr,
  input  wire logic [2:0]                        flagsIn,
  output logic                                   resValid,
  output logic                                   opIllegal,
  output logic [31:0]                            resData,
  output logic                                   resPair,
  output transfer_multiply_pkg::sel_t            resDst,
  output logic [2:0]                             flagsOut,
  output logic                                   flagsWr,
  output logic [15:0]                            probeData
);
  logic [31:0] resData_ff;
  logic        resValid_ff;
  logic        opIllegal_ff;
  logic        resPair_ff;
  sel_t        resDst_ff;
  logic [2:0]  flagsOut_ff;
  logic        flagsWr_ff;

  // Operand classes
  wire srcAddrReg = (srcSel == SEL_ADDR0) || (srcSel == SEL_ADDR1);
  wire dstAddrReg = (dstSel == SEL_ADDR0) || (dstSel == SEL_ADDR1);

  // Quick immediate range check
  wire signed [15:0] immSigned = immVal;
  wire quickBad = (opFmt == FMT_QUICK) && ((immSigned < `IMM4_MIN) || (immSigned > `IMM4_MAX)); // [RL1]

  // Short format legality
  wire shortImmAddr = (srcSel == SEL_IMM) && dstAddrReg;                        // [RL6]
  wire shortSizeBad = opWord && !shortImmAddr;                                  // [RL2]
  wire shortSameBad = (srcSel == dstSel);                                       // [RL3]
  wire shortLowBad  = (srcSel == SEL_ACC_LOW) && (dstSel == SEL_ADDR0);         // [RL4]
  wire shortHighBad = (srcSel == SEL_ACC_HIGH) && (dstSel == SEL_ADDR1);        // [RL5]
  wire shortBad     = (opFmt == FMT_SHORT) && (shortSizeBad || shortSameBad || shortLowBad || shortHighBad);
  wire zeroBad      = (opFmt == FMT_ZERO) && opWord;

  wire plainBad  = (opCode == OP_PLAIN) && (quickBad || shortBad || zeroBad);
  wire nibbleBad = (opCode == OP_NIBBLE) && (srcSel != SEL_ACC_LOW) && (dstSel != SEL_ACC_LOW); // [RL9]
  wire isMul     = (opCode == OP_SMUL) || (opCode == OP_UMUL);
  wire mulBad    = isMul && !opWord && srcAddrReg && dstAddrReg;                // [RL16]
  wire illegal   = plainBad || nibbleBad || mulBad;

  // Plain transfer value, zero store and byte zero extension for every destination
  wire [15:0] plainSrc = (opFmt == FMT_ZERO) ? `RESET_WORD : srcVal;
  wire [15:0] plainVal = opWord ? plainSrc : {8'h00, plainSrc[`BYTE_W-1:0]};

  // Nibble transfer
  wire [3:0] srcHi = srcVal[`NIB_HI_MSB:`NIB_HI_LSB];
  wire [3:0] srcLo = srcVal[`NIB_LO_MSB:`NIB_LO_LSB];
  wire [3:0] dstHi = dstVal[`NIB_HI_MSB:`NIB_HI_LSB];
  wire [3:0] dstLo = dstVal[`NIB_LO_MSB:`NIB_LO_LSB];
  wire [7:0] nibVal = (nibDir == DIR_HH) ? {srcHi, dstLo} :                   // [RL8] [RL17]
                      (nibDir == DIR_HL) ? {dstHi, srcHi} :
                      (nibDir == DIR_LH) ? {srcLo, dstLo} :
                                           {dstHi, srcLo};

  // Multiplier operands; byte size takes low 8 bits of any register
  wire        mulSigned = (opCode == OP_SMUL);
  wire [7:0]  srcB      = srcVal[`BYTE_W-1:0];                                  // [RL14]
  wire [7:0]  dstB      = dstVal[`BYTE_W-1:0];                                  // [RL14]
  wire [16:0] srcExt    = opWord ? {mulSigned & srcVal[`WORD_W-1], srcVal}
                                 : {{9{mulSigned & srcB[`BYTE_W-1]}}, srcB};
  wire [16:0] dstExt    = opWord ? {mulSigned & dstVal[`WORD_W-1], dstVal}
                                 : {{9{mulSigned & dstB[`BYTE_W-1]}}, dstB};
  wire signed [33:0] mulFull = $signed(srcExt) * $signed(dstExt);              // [RL10] [RL11]
  wire [31:0] mulVal = opWord ? mulFull[31:0] : {16'h0000, mulFull[15:0]};      // [RL12] [RL13]
  wire pairDst = isMul && opWord
                 && ((dstSel == SEL_DATA0) || (dstSel == SEL_DATA1) || (dstSel == SEL_ADDR0)); // [RL15]

  // Flag update: sign and zero for plain transfer only
  wire [15:0] plainMsk = opWord ? plainVal : {8'h00, plainSrc[`BYTE_W-1:0]};
  wire        plainNeg = opWord ? plainVal[`WORD_W-1] : plainSrc[`BYTE_W-1];
  wire        plainZ   = (plainMsk == `RESET_WORD);
  wire [2:0]  nxtFlags = (opCode == OP_PLAIN) ? {flagsIn[2], plainNeg, plainZ} : flagsIn;
  wire        nxtFlagsWr = (opCode == OP_PLAIN);

  logic [31:0] nxt_resData;
  always_comb begin
    unique case (opCode)
      OP_PLAIN:    nxt_resData = {16'h0000, plainVal};
      OP_EFF_ADDR: nxt_resData = {12'h000, srcAddr};                            // [RL7]
      OP_NIBBLE:   nxt_resData = {24'h000000, nibVal};
      OP_SMUL,
      OP_UMUL:     nxt_resData = mulVal;
      default:     nxt_resData = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resValid_ff  <= 1'b0;
      opIllegal_ff <= 1'b0;
      resData_ff   <= 32'h00000000;
      resPair_ff   <= 1'b0;
      resDst_ff    <= SEL_ACC_LOW;
      flagsOut_ff  <= 3'h0;
      flagsWr_ff   <= 1'b0;
    end else if (clkEn) begin
      resValid_ff  <= opValid && !illegal;
      opIllegal_ff <= opValid && illegal;
      flagsWr_ff   <= opValid && !illegal && nxtFlagsWr; // [RL7] [RL10] [RL11]
      if (opValid && !illegal) begin
        resData_ff  <= nxt_resData;
        resPair_ff  <= pairDst;
        resDst_ff   <= dstSel;
        flagsOut_ff <= nxtFlags;
      end
    end
  end

  // Scratch bank keeps last results for readback
  wire [3:0] dstCode = dstSel;
  wire [3:0] srcCode = srcSel;
  wire       bankWr  = opValid && !illegal;
  reg_bank uBank (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .wrIdx    (dstCode[2:0]),
    .wrData   (nxt_resData[15:0]),
    .wrEn     (bankWr),
    .rdIdx    (srcCode[2:0]),
    .rdData   (probeData)
  );

  assign resValid  = resValid_ff;
  assign opIllegal = opIllegal_ff;
  assign resData   = resData_ff;
  assign resPair   = resPair_ff;
  assign resDst    = resDst_ff;
  assign flagsOut  = flagsOut_ff;
  assign flagsWr   = flagsWr_ff;

  a_quick_imm_range: assert property (@(posedge core_clk) disable iff (!nrst) // [RL1]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_QUICK && ($signed(immVal) > 7) |=> opIllegal)
    else $error("quick immediate out of range accepted");
  a_short_byte_only: assert property (@(posedge core_clk) disable iff (!nrst) // [RL2]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && opWord && srcSel != SEL_IMM |=> !resValid)
    else $error("short word transfer accepted");
  a_short_same_reg: assert property (@(posedge core_clk) disable iff (!nrst) // [RL3]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && srcSel == dstSel |=> opIllegal)
    else $error("short same register accepted");
  a_low_to_addr: assert property (@(posedge core_clk) disable iff (!nrst) // [RL4]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && srcSel == SEL_ACC_LOW && dstSel == SEL_ADDR0
    |=> opIllegal)
    else $error("low byte to first address accepted");
  a_high_to_addr: assert property (@(posedge core_clk) disable iff (!nrst) // [RL5]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && srcSel == SEL_ACC_HIGH && dstSel == SEL_ADDR1
    |=> opIllegal)
    else $error("high byte to second address accepted");
  a_imm_word_addr: assert property (@(posedge core_clk) disable iff (!nrst) // [RL6]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && opWord && srcSel == SEL_IMM
    && dstSel == SEL_ADDR0 |=> resValid && resData[15:0] == $past(srcVal))
    else $error("short immediate word to address refused");
  a_eff_addr_val: assert property (@(posedge core_clk) disable iff (!nrst) // [RL7]
    clkEn && opValid && opCode == OP_EFF_ADDR |=> resValid && !flagsWr && resData[19:0] == $past(srcAddr))
    else $error("effective address result wrong");
  a_nibble_acc: assert property (@(posedge core_clk) disable iff (!nrst) // [RL9]
    clkEn && opValid && opCode == OP_NIBBLE && srcSel != SEL_ACC_LOW && dstSel != SEL_ACC_LOW |=> opIllegal)
    else $error("nibble transfer without low accumulator accepted");
  a_nibble_keep: assert property (@(posedge core_clk) disable iff (!nrst) // [RL17]
    clkEn && opValid && opCode == OP_NIBBLE && nibDir == DIR_LL && !illegal
    |=> resData[7:0] == {$past(dstVal[7:4]), $past(srcVal[3:0])})
    else $error("nibble transfer corrupted other nibble");
  a_umul_byte: assert property (@(posedge core_clk) disable iff (!nrst) // [RL12]
    clkEn && opValid && opCode == OP_UMUL && !opWord && !illegal
    |=> resData[15:0] == $past(srcVal[7:0]) * $past(dstVal[7:0]) && resData[31:16] == 16'h0000 && !flagsWr)
    else $error("unsigned byte product wrong");
  a_smul_word: assert property (@(posedge core_clk) disable iff (!nrst) // [RL13]
    clkEn && opValid && opCode == OP_SMUL && opWord
    |=> $signed(resData) == $signed($past(srcVal)) * $signed($past(dstVal)))
    else $error("signed word product wrong");
  a_pair_dest: assert property (@(posedge core_clk) disable iff (!nrst) // [RL15]
    clkEn && opValid && isMul && opWord && dstSel == SEL_ADDR0 |=> resPair)
    else $error("word product not sent to register pair");
  a_mul_addr_pair: assert property (@(posedge core_clk) disable iff (!nrst) // [RL16]
    clkEn && opValid && isMul && !opWord && srcAddrReg && dstAddrReg |=> opIllegal && !resValid)
    else $error("byte multiply on two address registers accepted");

  a_quick_imm_low: assert property (@(posedge core_clk) disable iff (!nrst) // [RL1]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_QUICK && ($signed(immVal) < `IMM4_MIN) |=> opIllegal)
    else $error("quick immediate below range accepted");

  a_quick_imm_ok: assert property (@(posedge core_clk) disable iff (!nrst) // [RL1]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_QUICK && ($signed(immVal) >= `IMM4_MIN)
    && ($signed(immVal) <= `IMM4_MAX) |=> resValid && flagsWr)
    else $error("quick immediate in range refused");

  a_short_imm_reg: assert property (@(posedge core_clk) disable iff (!nrst) // [RL2]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && opWord && srcSel == SEL_IMM && !dstAddrReg
    |=> opIllegal)
    else $error("short immediate word to register accepted");

  a_same_reg_held: assert property (@(posedge core_clk) disable iff (!nrst) // [RL3]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && srcSel == dstSel
    |=> !resValid && !flagsWr && $stable(resData))
    else $error("short same register changed result");

  a_low_to_second: assert property (@(posedge core_clk) disable iff (!nrst) // [RL4]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && !opWord && srcSel == SEL_ACC_LOW
    && dstSel == SEL_ADDR1 |=> resValid && resData[15:0] == {8'h00, $past(srcVal[7:0])})
    else $error("low byte to second address refused");

  a_high_to_first: assert property (@(posedge core_clk) disable iff (!nrst) // [RL5]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && !opWord && srcSel == SEL_ACC_HIGH
    && dstSel == SEL_ADDR0 |=> resValid && resData[15:0] == {8'h00, $past(srcVal[7:0])})
    else $error("high byte to first address refused");

  a_imm_byte_addr: assert property (@(posedge core_clk) disable iff (!nrst) // [RL6]
    clkEn && opValid && opCode == OP_PLAIN && opFmt == FMT_SHORT && !opWord && srcSel == SEL_IMM && dstAddrReg
    |=> resValid && resData[15:0] == {8'h00, $past(srcVal[7:0])})
    else $error("short immediate byte to address refused");

  a_eff_addr_dst: assert property (@(posedge core_clk) disable iff (!nrst) // [RL7]
    clkEn && opValid && opCode == OP_EFF_ADDR |=> resDst == $past(dstSel) && resData[31:20] == 12'h000)
    else $error("effective address destination wrong");

  a_nibble_hh: assert property (@(posedge core_clk) disable iff (!nrst) // [RL8]
    clkEn && opValid && opCode == OP_NIBBLE && nibDir == DIR_HH && !illegal
    |=> resData[7:0] == {$past(srcVal[7:4]), $past(dstVal[3:0])})
    else $error("nibble high to high wrong");

  a_nibble_hl: assert property (@(posedge core_clk) disable iff (!nrst) // [RL8]
    clkEn && opValid && opCode == OP_NIBBLE && nibDir == DIR_HL && !illegal
    |=> resData[7:0] == {$past(dstVal[7:4]), $past(srcVal[7:4])})
    else $error("nibble high to low wrong");

  a_nibble_lh: assert property (@(posedge core_clk) disable iff (!nrst) // [RL8]
    clkEn && opValid && opCode == OP_NIBBLE && nibDir == DIR_LH && !illegal
    |=> resData[7:0] == {$past(srcVal[3:0]), $past(dstVal[3:0])})
    else $error("nibble low to high wrong");

  a_nibble_flags: assert property (@(posedge core_clk) disable iff (!nrst) // [RL8]
    clkEn && opValid && opCode == OP_NIBBLE && !illegal |=> resValid && !flagsWr)
    else $error("nibble transfer touched flags");

  a_smul_byte: assert property (@(posedge core_clk) disable iff (!nrst) // [RL10]
    clkEn && opValid && opCode == OP_SMUL && !opWord && !illegal
    |=> $signed(resData[15:0]) == $signed($past(srcVal[7:0])) * $signed($past(dstVal[7:0])))
    else $error("signed byte product wrong");

  a_umul_word: assert property (@(posedge core_clk) disable iff (!nrst) // [RL11]
    clkEn && opValid && opCode == OP_UMUL && opWord |=> resData == $past(srcVal) * $past(dstVal) && !flagsWr)
    else $error("unsigned word product wrong");

  a_mul_flags: assert property (@(posedge core_clk) disable iff (!nrst) // [RL10] [RL11]
    clkEn && opValid && isMul && !illegal |=> resValid && !flagsWr)
    else $error("multiply touched flags");

  a_byte_upper: assert property (@(posedge core_clk) disable iff (!nrst) // [RL12]
    clkEn && opValid && isMul && !opWord && !illegal |=> resData[31:16] == 16'h0000 && !resPair)
    else $error("byte product spilled past 16 bits");

  a_pair_data: assert property (@(posedge core_clk) disable iff (!nrst) // [RL15]
    clkEn && opValid && isMul && opWord && (dstSel == SEL_DATA0 || dstSel == SEL_DATA1) |=> resPair)
    else $error("word product not sent to data pair");

  a_pair_other: assert property (@(posedge core_clk) disable iff (!nrst) // [RL15]
    clkEn && opValid && isMul && opWord && !(dstSel inside {SEL_DATA0, SEL_DATA1, SEL_ADDR0}) |=> !resPair)
    else $error("word product sent to wrong pair");

  a_pair_plain: assert property (@(posedge core_clk) disable iff (!nrst) // [RL15]
    clkEn && opValid && !isMul && !illegal |=> !resPair)
    else $error("non-multiply result marked as pair");

  a_mul_one_addr: assert property (@(posedge core_clk) disable iff (!nrst) // [RL16]
    clkEn && opValid && isMul && !opWord && srcAddrReg && !dstAddrReg |=> resValid)
    else $error("byte multiply with one address register refused");

  a_addr_low_only: assert property (@(posedge core_clk) disable iff (!nrst) // [RL14]
    clkEn && opValid && opCode == OP_UMUL && !opWord && dstAddrReg && !srcAddrReg
    |=> resData[15:0] == $past(srcVal[7:0]) * $past(dstVal[7:0]))
    else $error("address register high byte used in product");
endmodule // transfer_multiply_exec

// file: verification/transfer_multiply_exec_tb.sv
// Self-checking testbench for the transfer and multiply execution block
`timescale 1ns/100ps
module transfer_multiply_exec_tb;
  import transfer_multiply_pkg::*;
  logic        core_clk;
  logic        nrst;
  logic        clkEn;
  logic        opValid;
  logic        opWord;
  op_t         opCode;
  fmt_t        opFmt;
  dir_t        nibDir;
  sel_t        srcSel;
  sel_t        dstSel;
  sel_t        resDst;
  logic [15:0] srcVal;
  logic [15:0] dstVal;
  logic [15:0] immVal;
  logic [19:0] srcAddr;
  logic [2:0]  flagsIn;
  logic [2:0]  flagsOut;
  logic        resValid;
  logic        opIllegal;
  logic        resPair;
  logic        flagsWr;
  logic [31:0] resData;
  logic [31:0] lastData;
  logic [31:0] lastM;
  logic [15:0] probeData;
  logic [15:0] bankModel [8];
  int          miscompares;
  int          checked;
  int          cycles;

  transfer_multiply_exec uut (
    .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .opValid(opValid), .opCode(opCode), .opFmt(opFmt),
    .nibDir(nibDir), .opWord(opWord), .srcSel(srcSel), .dstSel(dstSel), .srcVal(srcVal), .dstVal(dstVal),
    .immVal(immVal), .srcAddr(srcAddr), .flagsIn(flagsIn), .resValid(resValid), .opIllegal(opIllegal),
    .resData(resData), .resPair(resPair), .resDst(resDst), .flagsOut(flagsOut), .flagsWr(flagsWr),
    .probeData(probeData)
  );

  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  function automatic logic isAddr(sel_t s);
    return s == SEL_ADDR0 || s == SEL_ADDR1;
  endfunction

  // Presents one operation at a falling edge and checks the answer one cycle later
  task automatic run(op_t o, fmt_t f, dir_t d, logic w, sel_t s, sel_t t, logic [15:0] sv, logic [15:0] dv);
    logic               ill;
    logic               sm;
    logic [3:0]         n;
    logic [31:0]        e;
    logic [31:0]        m;
    logic [31:0]        a;
    logic [31:0]        b;
    logic signed [15:0] si;
    si = sv;
    ill = 1'b0;
    sm = o == OP_SMUL;
    m = 32'hFFFFFFFF;
    e = w ? {16'h0000, sv} : {24'h000000, sv[7:0]};
    if (o == OP_PLAIN && f == FMT_QUICK) ill = si < -8 || si > 7;
    if (o == OP_PLAIN && f == FMT_SHORT) ill = (w && !(s == SEL_IMM && isAddr(t))) || s == t
      || (s == SEL_ACC_LOW && t == SEL_ADDR0) || (s == SEL_ACC_HIGH && t == SEL_ADDR1);
    if (o == OP_PLAIN && f == FMT_ZERO) ill = w;
    if (o == OP_PLAIN && f == FMT_ZERO) e = 32'h00000000;
    if (o == OP_EFF_ADDR) e = {12'h000, srcAddr};
    if (o == OP_EFF_ADDR) m = 32'hFFFFFFFF;
    if (o == OP_NIBBLE) begin
      ill = s != SEL_ACC_LOW && t != SEL_ACC_LOW;
      n = (d == DIR_HH || d == DIR_HL) ? sv[7:4] : sv[3:0];
      e = (d == DIR_HH || d == DIR_LH) ? {24'h000000, n, dv[3:0]} : {24'h000000, dv[7:4], n};
      m = 32'h000000FF;
    end
    if (o == OP_SMUL || o == OP_UMUL) begin
      ill = !w && isAddr(s) && isAddr(t);
      a = w ? {{16{sm & sv[15]}}, sv} : {{24{sm & sv[7]}}, sv[7:0]};
      b = w ? {{16{sm & dv[15]}}, dv} : {{24{sm & dv[7]}}, dv[7:0]};
      e = a * b;
      if (!w) e[31:16] = 16'h0000;
    end
    opCode = o;
    opFmt = f;
    nibDir = d;
    opWord = w;
    srcSel = s;
    dstSel = t;
    srcVal = sv;
    immVal = sv;
    dstVal = dv;
    flagsIn = 3'($urandom);
    @(negedge core_clk);
    chk("probeData", {16'h0000, bankModel[3'(s)]}, {16'h0000, probeData});
    chk("opIllegal", {31'h0, ill}, {31'h0, opIllegal});
    chk("resValid", {31'h0, !ill}, {31'h0, resValid});
    chk("flagsWr", {31'h0, !ill && o == OP_PLAIN}, {31'h0, flagsWr});
    if (ill) begin
      chk("resData held", lastData & lastM, resData & lastM);
    end else begin
      chk("resData", e & m, resData & m);
      chk("resDst", 32'(t), 32'(resDst));
      if (o == OP_PLAIN) chk("flagsOut", {29'h0, flagsIn[2], w ? e[15] : e[7], w ? e[15:0] == 0 : e[7:0] == 0},
        {29'h0, flagsOut});
      chk("resPair", {31'h0, (sm || o == OP_UMUL) && w && (t == SEL_DATA0 || t == SEL_DATA1 || t == SEL_ADDR0)},
        {31'h0, resPair});
      lastData = e;
      lastM = m;
      bankModel[3'(t)] = e[15:0];
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(38));
    {nrst, clkEn, opValid, opWord, srcVal, dstVal, immVal, srcAddr, flagsIn} = '0;
    opCode = OP_PLAIN;
    opFmt = FMT_GENERAL;
    nibDir = DIR_HH;
    srcSel = SEL_ACC_LOW;
    dstSel = SEL_ACC_LOW;
    foreach (bankModel[i]) bankModel[i] = 16'h0000;
    lastData = 32'h00000000;
    lastM = 32'hFFFFFFFF;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    clkEn = 1'b1;
    chk("reset resData", 32'h00000000, resData);
    opValid = 1'b1;
    srcAddr = 20'hABCDE;
    run(OP_UMUL, FMT_GENERAL, DIR_HH, 1'b0, SEL_R1L, SEL_ACC_LOW, 16'h0003, 16'h0005);
    run(OP_PLAIN, FMT_QUICK, DIR_HH, 1'b0, SEL_IMM, SEL_R1L, 16'hFFF8, 16'h0000);
    run(OP_PLAIN, FMT_QUICK, DIR_HH, 1'b1, SEL_IMM, SEL_DATA2, 16'h0007, 16'h0000);
    run(OP_PLAIN, FMT_QUICK, DIR_HH, 1'b0, SEL_IMM, SEL_R1L, 16'h0008, 16'h0000);
    run(OP_PLAIN, FMT_QUICK, DIR_HH, 1'b1, SEL_IMM, SEL_R1L, 16'hFFF7, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b1, SEL_R1L, SEL_ACC_LOW, 16'h1234, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b1, SEL_IMM, SEL_ADDR0, 16'h8001, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b0, SEL_IMM, SEL_ADDR1, 16'h0080, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b0, SEL_ACC_HIGH, SEL_ACC_HIGH, 16'h0011, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b0, SEL_ACC_LOW, SEL_ADDR0, 16'h0022, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b0, SEL_ACC_LOW, SEL_ADDR1, 16'h0000, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b0, SEL_ACC_HIGH, SEL_ADDR1, 16'h0033, 16'h0000);
    run(OP_PLAIN, FMT_SHORT, DIR_HH, 1'b0, SEL_ACC_HIGH, SEL_ADDR0, 16'h00F3, 16'h0000);
    run(OP_EFF_ADDR, FMT_GENERAL, DIR_HH, 1'b1, SEL_MEM, SEL_ADDR0, 16'h5555, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      run(OP_NIBBLE, FMT_GENERAL, dir_t'(i), 1'b0, SEL_ACC_LOW, SEL_MEM, 16'h00A5, 16'h003C);
      run(OP_NIBBLE, FMT_GENERAL, dir_t'(i), 1'b0, SEL_R1H, SEL_ACC_LOW, 16'h0F96, 16'h00E1);
    end
    run(OP_NIBBLE, FMT_GENERAL, DIR_LL, 1'b0, SEL_R1L, SEL_MEM, 16'h0012, 16'h0034);
    run(OP_SMUL, FMT_GENERAL, DIR_HH, 1'b0, SEL_ADDR0, SEL_ACC_LOW, 16'h1280, 16'h3480);
    run(OP_SMUL, FMT_GENERAL, DIR_HH, 1'b1, SEL_R1L, SEL_DATA0, 16'h8000, 16'hFFFF);
    run(OP_UMUL, FMT_GENERAL, DIR_HH, 1'b1, SEL_MEM, SEL_DATA1, 16'hFFFF, 16'hFFFF);
    run(OP_UMUL, FMT_GENERAL, DIR_HH, 1'b1, SEL_MEM, SEL_ADDR0, 16'h8000, 16'h0003);
    run(OP_UMUL, FMT_GENERAL, DIR_HH, 1'b0, SEL_ADDR1, SEL_ADDR0, 16'h0002, 16'h0003);
    run(OP_SMUL, FMT_GENERAL, DIR_HH, 1'b1, SEL_ADDR1, SEL_ADDR0, 16'hFFFE, 16'h0003);
    clkEn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("frozen resData", lastData & lastM, resData & lastM);
    clkEn = 1'b1;
    for (int i = 0; i < 300; i++) begin
      srcAddr = 20'($urandom);
      run(op_t'($urandom_range(4)), fmt_t'($urandom_range(3)), dir_t'($urandom_range(3)), 1'($urandom),
        sel_t'($urandom_range(11)), sel_t'($urandom_range(11)),
        $urandom_range(3) == 0 ? 16'($urandom_range(19)) - 16'h000A : 16'($urandom), 16'($urandom));
    end
    opValid = 1'b0;
    @(negedge core_clk);
    finish_test();
  end
endmodule // transfer_multiply_exec_tb
